// ### include/pwm_drive_pkg.sv
package pwm_drive_pkg;
    // register byte offsets
    localparam logic [7:0]  OFS_ROLE      = 8'h00;
    localparam logic [7:0]  OFS_RATE      = 8'h04;
    localparam logic [7:0]  OFS_CEIL      = 8'h08;
    localparam logic [7:0]  OFS_PHASE     = 8'h0C;
    localparam logic [7:0]  OFS_SSTEP     = 8'h10;
    localparam logic [7:0]  OFS_STATUS    = 8'h14;
    localparam logic [7:0]  OFS_CLCNT     = 8'h18;
    // reset values
    localparam logic [1:0]  ROLE_RST      = 2'h0;
    localparam logic [7:0]  RATE_RST      = 8'h34;
    localparam logic [9:0]  CEIL_RST      = 10'h3FF;
    localparam logic [15:0] PHASE_RST     = 16'h0000;
    localparam logic [7:0]  SSTEP_RST     = 8'h04;
    // sync roles
    localparam logic [1:0]  ROLE_MASTER   = 2'h0;
    localparam logic [1:0]  ROLE_SLAVE    = 2'h1;
    localparam logic [1:0]  ROLE_SHIFT    = 2'h2;
    // phase accumulator: f_sw = f_clk * rate / 2^16
    localparam longint      F_CLK_HZ      = 125_000_000;
    localparam longint      F_MIN_HZ      = 50_000;
    localparam longint      F_MAX_HZ      = 300_000;
    localparam longint      ACC_SPAN      = 65536;
    localparam logic [7:0]  RATE_MIN      = 8'((F_MIN_HZ * ACC_SPAN + F_CLK_HZ - 1) / F_CLK_HZ);
    localparam logic [7:0]  RATE_MAX      = 8'(F_MAX_HZ * ACC_SPAN / F_CLK_HZ);
    // level codes, 1 lsb = 4 V / 1024
    localparam logic [11:0] LVL_COMP_LOW  = 12'h080;
    localparam logic [11:0] LVL_COMP_HIGH = 12'h480;
    localparam logic [11:0] LVL_SS_ENABLE = 12'h085;
    localparam logic [11:0] LVL_SS_TOP    = 12'h500;
    // duty in 1/1024 of a period, hiccup count in switching periods
    localparam logic [9:0]  DUTY_CEIL     = 10'h3EB;
    localparam logic [9:0]  DUTY_FULL     = 10'h3FF;
    localparam logic [9:0]  HICCUP_CYCLES = 10'h1F4;

    typedef enum logic [2:0] {ST_OFF, ST_START, ST_RUN, ST_HICCUP, ST_HOLD} state_t;
endpackage : pwm_drive_pkg

// ### include/timebase_if.sv
`timescale 1ns/1ps
interface timebase_if;
    logic [7:0]  rate;
    logic [1:0]  role;
    logic [15:0] phase_delay;
    logic        sync_edge;
    logic [9:0]  ramp;
    logic        period_start;
    logic        sync_pull_low;
    modport tb  (input rate, role, phase_delay, sync_edge,
                 output ramp, period_start, sync_pull_low);
    modport ctl (output rate, role, phase_delay, sync_edge,
                 input ramp, period_start, sync_pull_low);
endinterface : timebase_if

// ### rtl/switching_timebase.sv
`timescale 1ns/1ps
module switching_timebase (
    // clock and reset
    input  wire logic    hclk,
    input  wire logic    hresetn,
    // ramp and sync link
    timebase_if.tb       tb
);
    logic [15:0] acc_reg;
    logic [15:0] dly_reg;
    logic        dly_busy_reg;

    wire logic [7:0]  rate_eff    = (tb.rate < pwm_drive_pkg::RATE_MIN) ? pwm_drive_pkg::RATE_MIN :
                                    (tb.rate > pwm_drive_pkg::RATE_MAX) ? pwm_drive_pkg::RATE_MAX :
                                    tb.rate;
    wire logic [16:0] acc_sum     = {1'b0, acc_reg} + {9'h000, rate_eff};
    wire logic        lock_direct = tb.sync_edge && tb.role == pwm_drive_pkg::ROLE_SLAVE;
    wire logic        shift_start = tb.sync_edge && tb.role != pwm_drive_pkg::ROLE_SLAVE
                                    && tb.role != pwm_drive_pkg::ROLE_MASTER;
    wire logic        dly_done    = dly_busy_reg && dly_reg == 16'h0000;
    wire logic        restart     = lock_direct || dly_done;
    wire logic [15:0] acc_next    = restart ? 16'h0000 : acc_sum[15:0];
    wire logic [15:0] dly_next    = shift_start ? tb.phase_delay :
                                    (dly_busy_reg && !dly_done) ? dly_reg - 16'h0001 : dly_reg;
    wire logic        dly_busy_next = shift_start || (dly_busy_reg && !dly_done);

    // a missing external clock leaves the ramp free-running
    assign tb.period_start  = restart || acc_sum[16];
    assign tb.ramp          = acc_reg[15:6];
    assign tb.sync_pull_low = tb.role == pwm_drive_pkg::ROLE_MASTER && acc_reg[15];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_reg      <= 16'h0000;
            dly_reg      <= 16'h0000;
            dly_busy_reg <= 1'b0;
        end else begin
            acc_reg      <= acc_next;
            dly_reg      <= dly_next;
            dly_busy_reg <= dly_busy_next;
        end
    end
endmodule : switching_timebase

// ### rtl/buck_boost_pwm_drive.sv
`timescale 1ns/1ps
module buck_boost_pwm_drive (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // control pins
    input  wire logic        enable_in,
    input  wire logic        mode_in,
    input  wire logic        fault_n,
    input  wire logic        overtemp_stop,
    input  wire logic        peak_over,
    input  wire logic [11:0] comp_level,
    // open-drain sync pin
    input  wire logic        sync_in,
    output logic             sync_out,
    output logic             sync_oe,
    // gate drives
    output logic             high_side_drive,
    output logic             low_side_drive
);
    timebase_if tb_bus ();

    switching_timebase u_timebase (
        .hclk    (hclk),
        .hresetn (hresetn),
        .tb      (tb_bus)
    );

    // pin synchronisers
    logic [5:0] pin_meta_reg;
    logic [5:0] pin_sync_reg;
    logic       fault_n_d_reg;
    logic       sync_d_reg;

    wire logic [5:0] pin_raw = {sync_in, peak_over, overtemp_stop, fault_n, mode_in, enable_in};
    wire logic en_s      = pin_sync_reg[0];
    wire logic mode_s    = pin_sync_reg[1];
    wire logic fault_n_s = pin_sync_reg[2];
    wire logic tsd_s     = pin_sync_reg[3];
    wire logic peak_s    = pin_sync_reg[4];
    wire logic sync_s    = pin_sync_reg[5];
    wire logic stop_s    = !fault_n_s || tsd_s;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // fault_n and sync idle high: no false edge after reset
            pin_meta_reg  <= 6'h24;
            pin_sync_reg  <= 6'h24;
            fault_n_d_reg <= 1'b1;
            sync_d_reg    <= 1'b1;
        end else begin
            pin_meta_reg  <= pin_raw;
            pin_sync_reg  <= pin_meta_reg;
            fault_n_d_reg <= fault_n_s;
            sync_d_reg    <= sync_s;
        end
    end

    // software registers
    logic [1:0]  role_reg;
    logic [7:0]  rate_reg;
    logic [9:0]  ceil_reg;
    logic [15:0] phase_reg;
    logic [7:0]  sstep_reg;
    // bus data phase
    logic [7:0]  addr_reg;
    logic        wr_pend_reg;
    logic        rd_wait_reg;
    logic [31:0] hrdata_reg;
    // control core
    pwm_drive_pkg::state_t state_reg;
    pwm_drive_pkg::state_t state_next;
    logic        mode_reg;
    logic [11:0] ss_reg;
    logic [9:0]  cnt_reg;
    logic        peak_seen_reg;
    logic [9:0]  duty_reg;
    logic        hdrv_reg;
    logic        ldrv_reg;

    wire logic bus_go   = hsel && hready && htrans[1];
    wire logic wr_role  = wr_pend_reg && addr_reg == pwm_drive_pkg::OFS_ROLE;
    wire logic wr_rate  = wr_pend_reg && addr_reg == pwm_drive_pkg::OFS_RATE;
    wire logic wr_ceil  = wr_pend_reg && addr_reg == pwm_drive_pkg::OFS_CEIL;
    wire logic wr_phase = wr_pend_reg && addr_reg == pwm_drive_pkg::OFS_PHASE;
    wire logic wr_sstep = wr_pend_reg && addr_reg == pwm_drive_pkg::OFS_SSTEP;

    wire logic [31:0] status_w = {6'h00, duty_reg, 10'h000, ldrv_reg, hdrv_reg,
                                  mode_reg, state_reg};
    wire logic [31:0] rd_mux =
        (addr_reg == pwm_drive_pkg::OFS_ROLE)   ? {30'h00000000, role_reg}  :
        (addr_reg == pwm_drive_pkg::OFS_RATE)   ? {24'h000000, rate_reg}    :
        (addr_reg == pwm_drive_pkg::OFS_CEIL)   ? {22'h000000, ceil_reg}    :
        (addr_reg == pwm_drive_pkg::OFS_PHASE)  ? {16'h0000, phase_reg}     :
        (addr_reg == pwm_drive_pkg::OFS_SSTEP)  ? {24'h000000, sstep_reg}   :
        (addr_reg == pwm_drive_pkg::OFS_STATUS) ? status_w                  :
        (addr_reg == pwm_drive_pkg::OFS_CLCNT)  ? {22'h000000, cnt_reg}     :
        32'h00000000;

    // reads take one wait state so a preceding write is visible
    assign hreadyout = !rd_wait_reg;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_reg    <= 8'h00;
            wr_pend_reg <= 1'b0;
            rd_wait_reg <= 1'b0;
            hrdata_reg  <= 32'h00000000;
        end else begin
            if (bus_go) begin
                addr_reg <= haddr[7:0];
            end
            wr_pend_reg <= bus_go && hwrite;
            rd_wait_reg <= bus_go && !hwrite;
            if (rd_wait_reg) begin
                hrdata_reg <= rd_mux;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            role_reg  <= pwm_drive_pkg::ROLE_RST;
            rate_reg  <= pwm_drive_pkg::RATE_RST;
            ceil_reg  <= pwm_drive_pkg::CEIL_RST;
            phase_reg <= pwm_drive_pkg::PHASE_RST;
            sstep_reg <= pwm_drive_pkg::SSTEP_RST;
        end else begin
            if (wr_role)  role_reg  <= hwdata[1:0];
            if (wr_rate)  rate_reg  <= hwdata[7:0];
            if (wr_ceil)  ceil_reg  <= hwdata[9:0];
            if (wr_phase) phase_reg <= hwdata[15:0];
            if (wr_sstep) sstep_reg <= hwdata[7:0];
        end
    end

    // timebase link
    assign tb_bus.rate        = rate_reg;
    assign tb_bus.role        = role_reg;
    assign tb_bus.phase_delay = phase_reg;
    assign tb_bus.sync_edge   = sync_s && !sync_d_reg;
    wire logic period_start   = tb_bus.period_start;
    wire logic [9:0] ramp     = tb_bus.ramp;

    // open drain: only ever pulls low
    assign sync_out = 1'b0;
    assign sync_oe  = tb_bus.sync_pull_low;

    // error level or soft start level to duty code
    function automatic logic [9:0] level_duty(input logic [11:0] lvl);
        logic [11:0] rel;
        rel = lvl - pwm_drive_pkg::LVL_COMP_LOW;
        if (lvl <= pwm_drive_pkg::LVL_COMP_LOW) begin
            level_duty = 10'h000;
        end else if (lvl >= pwm_drive_pkg::LVL_COMP_HIGH) begin
            level_duty = pwm_drive_pkg::DUTY_FULL;
        end else begin
            level_duty = rel[9:0];
        end
    endfunction : level_duty

    wire logic [9:0] comp_duty = level_duty(comp_level);
    wire logic [9:0] ss_duty   = level_duty(ss_reg);
    wire logic [9:0] ceil_eff  = (ceil_reg > pwm_drive_pkg::DUTY_CEIL) ?
                                 pwm_drive_pkg::DUTY_CEIL : ceil_reg;
    wire logic [9:0] min_cs    = (ceil_eff < ss_duty) ? ceil_eff : ss_duty;
    wire logic [9:0] duty_next = (min_cs < comp_duty) ? min_cs : comp_duty;

    // overcurrent and hiccup bookkeeping
    wire logic peak_now  = peak_seen_reg || peak_s;
    wire logic trip      = peak_now && cnt_reg == pwm_drive_pkg::HICCUP_CYCLES;
    wire logic hic_done  = cnt_reg == pwm_drive_pkg::HICCUP_CYCLES - 10'h001;
    wire logic in_run    = state_reg == pwm_drive_pkg::ST_RUN;
    wire logic in_hiccup = state_reg == pwm_drive_pkg::ST_HICCUP;
    wire logic [9:0] cnt_next =
        (state_next != state_reg)   ? 10'h000 :
        (period_start && in_run)    ? (peak_now ? cnt_reg + 10'h001 : 10'h000) :
        (period_start && in_hiccup) ? cnt_reg + 10'h001 : cnt_reg;

    // mode latch
    wire logic supply_rise = state_reg == pwm_drive_pkg::ST_OFF && en_s;
    wire logic fault_rise  = fault_n_s && !fault_n_d_reg && en_s;
    wire logic mode_next   = (supply_rise || fault_rise) ? mode_s : mode_reg;

    // soft start level
    wire logic ss_clear = state_next == pwm_drive_pkg::ST_OFF
                       || state_next == pwm_drive_pkg::ST_HOLD
                       || state_next == pwm_drive_pkg::ST_HICCUP;
    wire logic ss_grow  = period_start && ss_reg < pwm_drive_pkg::LVL_SS_TOP
                       && (state_reg == pwm_drive_pkg::ST_START || in_run);
    wire logic [11:0] ss_sum  = ss_reg + {4'h0, sstep_reg};
    wire logic [11:0] ss_next = ss_clear ? 12'h000 :
                                !ss_grow ? ss_reg :
                                (ss_sum > pwm_drive_pkg::LVL_SS_TOP) ?
                                pwm_drive_pkg::LVL_SS_TOP : ss_sum;

    always_comb begin
        state_next = state_reg;
        if (!en_s) begin
            state_next = pwm_drive_pkg::ST_OFF;
        end else if (stop_s) begin
            state_next = pwm_drive_pkg::ST_HOLD;
        end else begin
            unique case (state_reg)
                pwm_drive_pkg::ST_OFF,
                pwm_drive_pkg::ST_HOLD: begin
                    state_next = pwm_drive_pkg::ST_START;
                end
                pwm_drive_pkg::ST_START: begin
                    if (ss_reg > pwm_drive_pkg::LVL_SS_ENABLE) begin
                        state_next = pwm_drive_pkg::ST_RUN;
                    end
                end
                pwm_drive_pkg::ST_RUN: begin
                    if (period_start && trip) begin
                        state_next = pwm_drive_pkg::ST_HICCUP;
                    end
                end
                pwm_drive_pkg::ST_HICCUP: begin
                    if (period_start && hic_done) begin
                        state_next = pwm_drive_pkg::ST_START;
                    end
                end
            endcase
        end
    end

    // comparator: ramp below duty code and below ceiling
    wire logic pwm_on = in_run && state_next == pwm_drive_pkg::ST_RUN
                     && ramp < duty_reg && ramp < ceil_eff;
    wire logic hdrv_next = pwm_on && mode_reg;
    wire logic ldrv_next = pwm_on && !mode_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg     <= pwm_drive_pkg::ST_OFF;
            mode_reg      <= 1'b0;
            ss_reg        <= 12'h000;
            cnt_reg       <= 10'h000;
            peak_seen_reg <= 1'b0;
            duty_reg      <= 10'h000;
            hdrv_reg      <= 1'b0;
            ldrv_reg      <= 1'b0;
        end else begin
            state_reg     <= state_next;
            mode_reg      <= mode_next;
            ss_reg        <= ss_next;
            cnt_reg       <= cnt_next;
            peak_seen_reg <= peak_s || (peak_seen_reg && !period_start);
            duty_reg      <= period_start ? duty_next : duty_reg;
            hdrv_reg      <= hdrv_next;
            ldrv_reg      <= ldrv_next;
        end
    end

    assign high_side_drive = hdrv_reg;
    assign low_side_drive  = ldrv_reg;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_boost_high_quiet: assert property (
        !mode_reg |-> !high_side_drive)
        else $error("high drive active in boost mode");
    chk_buck_low_quiet: assert property (
        mode_reg |-> !low_side_drive)
        else $error("low drive active in buck mode");
    chk_comp_floor_idle: assert property (
        (period_start && comp_level <= pwm_drive_pkg::LVL_COMP_LOW)
        |=> duty_reg == 10'h000 ##1 (!high_side_drive && !low_side_drive))
        else $error("drive switched with error below low threshold");
    chk_comp_top_ceiling: assert property (
        (period_start && comp_level >= pwm_drive_pkg::LVL_COMP_HIGH
         && ss_duty == pwm_drive_pkg::DUTY_FULL) |=> duty_reg == $past(ceil_eff))
        else $error("high error level did not give ceiling duty");
    chk_pulse_ceiling: assert property (
        (high_side_drive || low_side_drive) |-> $past(ramp) < $past(ceil_eff))
        else $error("pulse ran past duty ceiling");
    chk_ceiling_fallback: assert property (
        ceil_eff <= pwm_drive_pkg::DUTY_CEIL
        && (ceil_reg > pwm_drive_pkg::DUTY_CEIL || ceil_eff == ceil_reg))
        else $error("duty ceiling fallback wrong");
    chk_hiccup_entry: assert property (
        (in_run && period_start && peak_now && en_s && !stop_s
         && cnt_reg == pwm_drive_pkg::HICCUP_CYCLES) |=> in_hiccup && cnt_reg == 10'h000)
        else $error("hiccup not entered after overcurrent run");
    chk_hiccup_exit: assert property (
        (in_hiccup && period_start && hic_done && en_s && !stop_s)
        |=> state_reg == pwm_drive_pkg::ST_START && ss_reg == 12'h000)
        else $error("hiccup did not restart through soft start");
    chk_ss_gate: assert property (
        (state_reg == pwm_drive_pkg::ST_START ##1 in_run)
        |-> $past(ss_reg) > pwm_drive_pkg::LVL_SS_ENABLE)
        else $error("regulation began below soft start threshold");
    chk_fault_stop: assert property (
        (en_s && !fault_n_s) |=> state_reg == pwm_drive_pkg::ST_HOLD
        && ss_reg == 12'h000 && !high_side_drive && !low_side_drive)
        else $error("fault did not stop drives");
    chk_fault_restart: assert property (
        (fault_rise && !tsd_s) |=> state_reg == pwm_drive_pkg::ST_START)
        else $error("fault release did not restart");
    chk_tsd_discharge: assert property (
        (en_s && tsd_s) |=> ss_reg == 12'h000 && !high_side_drive && !low_side_drive)
        else $error("overtemperature did not discharge soft start");
    chk_enable_off: assert property (
        !en_s |=> state_reg == pwm_drive_pkg::ST_OFF && !high_side_drive && !low_side_drive)
        else $error("enable low did not shut down");
    chk_mode_held: assert property (
        (in_run ##1 in_run) |-> $stable(mode_reg))
        else $error("mode changed while running");
    chk_sync_input: assert property (
        role_reg != pwm_drive_pkg::ROLE_MASTER |-> !sync_oe)
        else $error("sync pin driven outside master role");

    cov_hiccup_cycle: cover property (in_hiccup ##1 state_reg == pwm_drive_pkg::ST_START);
    cov_buck_pulse: cover property (in_run && high_side_drive);
    cov_slave_lock: cover property (role_reg == pwm_drive_pkg::ROLE_SLAVE && tb_bus.sync_edge);
    cov_fault_recover: cover property (state_reg == pwm_drive_pkg::ST_HOLD
                                       ##1 state_reg == pwm_drive_pkg::ST_START);
endmodule : buck_boost_pwm_drive

// ### sim/gate_driver_model.sv
`timescale 1ns/1ps
// far side: error source and gate driver, measures drive pulses
module gate_driver_model (
    // clock and control
    input  wire logic        hclk,
    input  wire logic        clr,
    input  wire logic [11:0] target,
    // drives from the controller
    input  wire logic        high_side_drive,
    input  wire logic        low_side_drive,
    // error level and measurements
    output logic      [11:0] comp_level,
    output int               hi_max,
    output int               lo_max,
    output int               lo_pulses
);
    int hi_run;
    int lo_run;
    initial comp_level = 12'h000;
    always @(posedge hclk) begin
        comp_level <= target;
        hi_run = high_side_drive === 1'b1 ? hi_run + 1 : 0;
        lo_run = low_side_drive === 1'b1 ? lo_run + 1 : 0;
        if (clr) begin
            hi_max = 0;
            lo_max = 0;
            lo_pulses = 0;
        end
        if (hi_run > hi_max) hi_max = hi_run;
        if (lo_run > lo_max) lo_max = lo_run;
        if (lo_run == 1) lo_pulses++;
    end
endmodule : gate_driver_model

// ### sim/buck_boost_pwm_drive_control_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
    $display("mismatch at %0t: %h vs %h", $time, (a), (b)); end end
module buck_boost_pwm_drive_control_bench;
    logic hclk = 0, hresetn = 0, hwrite = 0, hrdy, en = 0, mode = 0, flt_n = 1, ot = 0;
    logic clr = 0, sync_oe, hi, lo, seen_oe = 0, pk = 0, ext_on = 0, resp, sout;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [11:0] target = 0, comp;
    int n_fail = 0, samples_checked = 0, hi_max, lo_max, lo_pulses, seed, k;
    int sync_cnt = 0;
    initial forever #4 hclk = ~hclk;
    // open-drain sync line: pull-up, master pulls low, else external clock
    wire sync_line = (sync_oe === 1'b1) ? 1'b0 : (!ext_on || sync_cnt < 100);
    always @(posedge hclk) sync_cnt <= (sync_cnt == 199) ? 0 : sync_cnt + 1;
    buck_boost_pwm_drive buck_boost_pwm_drive_inst (.hclk(hclk), .hresetn(hresetn),
        .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy), .hresp(resp),
        .enable_in(en), .mode_in(mode), .fault_n(flt_n), .overtemp_stop(ot),
        .peak_over(pk), .comp_level(comp), .sync_in(sync_line), .sync_out(sout),
        .sync_oe(sync_oe), .high_side_drive(hi), .low_side_drive(lo));
    gate_driver_model gate_driver_model_inst (.hclk(hclk), .clr(clr), .target(target),
        .high_side_drive(hi), .low_side_drive(lo), .comp_level(comp), .hi_max(hi_max),
        .lo_max(lo_max), .lo_pulses(lo_pulses));
    always @(posedge hclk) if (sync_oe === 1'b1) seen_oe <= 1'b1;
    // pulse length in clocks for a duty code at the top rate
    function automatic int exp_width(input int duty);
        return duty * 64 / pwm_drive_pkg::RATE_MAX;
    endfunction : exp_width
    task report_and_stop;
        $display("checked %0d, failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    task wait_ready;
        int i;
        @(posedge hclk);
        for (i = 0; hrdy !== 1'b1; i++) begin
            if (i > 50) begin
                n_fail++;
                report_and_stop;
            end
            @(posedge hclk);
        end
    endtask : wait_ready
    task wait_pulse;
        int i;
        for (i = 0; (hi | lo) !== 1'b1; i++) begin
            if (i > 1000) begin
                n_fail++;
                report_and_stop;
            end
            @(posedge hclk);
        end
    endtask : wait_pulse
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        wait_ready;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready;
        rd = hrdata;
    endtask : ahb
    task wait_state(input logic [2:0] s);
        int i;
        for (i = 0; i < 3000; i++) begin
            ahb(0, pwm_drive_pkg::OFS_STATUS, 0);
            if (rd[2:0] === s) return;
        end
        n_fail++;
        report_and_stop;
    endtask : wait_state
    task run(input int n, input logic rnd);
        clr <= 1;
        @(posedge hclk);
        clr <= 0;
        for (k = 0; k < n; k++) begin
            if (rnd && k % 400 == 0) target <= 12'h100 + 12'($unsigned($random(seed)) % 12'h37F);
            @(posedge hclk);
        end
    endtask : run
    initial begin
        seed = 32'hb52c0617;
        repeat (20) @(posedge hclk);
        hresetn <= 1;
        @(posedge hclk);
        ahb(0, pwm_drive_pkg::OFS_STATUS, 0);
        `CHK(rd[2:0], 3'h0)
        ahb(0, pwm_drive_pkg::OFS_RATE, 0);
        `CHK(rd, 32'h00000034)
        ahb(0, 8'h1C, 0);
        `CHK(rd, 32'h00000000)
        `CHK({resp, sout}, 2'b00)
        ahb(1, pwm_drive_pkg::OFS_RATE, 32'h0000009D);
        ahb(1, pwm_drive_pkg::OFS_SSTEP, 32'h000000FF);
        ahb(1, pwm_drive_pkg::OFS_CEIL, 32'h00000100);
        mode <= 1;
        en <= 1;
        target <= 12'h300;
        wait_state(3'h2);
        run(4000, 1);
        `CHK(lo_max, 0)
        `CHK(hi_max > 0 && hi_max <= exp_width(32'h100) + 2, 1'b1)
        `CHK(seen_oe, 1'b1)
        ahb(1, pwm_drive_pkg::OFS_CEIL, 32'h000003FF);
        target <= 12'hFFF;
        run(2000, 0);
        `CHK(hi_max >= exp_width(pwm_drive_pkg::DUTY_CEIL) - 3
             && hi_max <= exp_width(pwm_drive_pkg::DUTY_CEIL) + 3, 1'b1)
        target <= 12'h040;
        run(900, 0);
        run(1000, 0);
        `CHK(hi_max, 0)
        pk <= 1;
        run(1300, 0);
        ahb(0, pwm_drive_pkg::OFS_CLCNT, 0);
        `CHK(rd[9:0] >= 10'h003 && rd[9:0] <= 10'h004, 1'b1)
        pk <= 0;
        run(900, 0);
        ahb(0, pwm_drive_pkg::OFS_CLCNT, 0);
        `CHK(rd[9:0], 10'h000)
        target <= 12'h300;
        mode <= 0;
        run(900, 0);
        ahb(0, pwm_drive_pkg::OFS_STATUS, 0);
        `CHK(rd[3], 1'b1)
        wait_pulse;
        flt_n <= 0;
        repeat (4) @(posedge hclk);
        `CHK({hi, lo}, 2'b00)
        wait_state(3'h4);
        flt_n <= 1;
        wait_state(3'h2);
        `CHK(rd[3], 1'b0)
        run(4000, 0);
        `CHK(hi_max, 0)
        `CHK(lo_pulses > 0, 1'b1)
        wait_pulse;
        ot <= 1;
        repeat (4) @(posedge hclk);
        `CHK({hi, lo}, 2'b00)
        wait_state(3'h4);
        ot <= 0;
        wait_state(3'h2);
        target <= 12'h180;
        ext_on <= 1;
        ahb(1, pwm_drive_pkg::OFS_ROLE, pwm_drive_pkg::ROLE_SLAVE);
        run(2000, 0);
        `CHK(lo_pulses >= 9, 1'b1)
        `CHK(sync_oe, 1'b0)
        ahb(1, pwm_drive_pkg::OFS_PHASE, 32'h0000003C);
        ahb(1, pwm_drive_pkg::OFS_ROLE, pwm_drive_pkg::ROLE_SHIFT);
        run(2000, 0);
        `CHK(lo_pulses >= 9, 1'b1)
        wait_pulse;
        en <= 0;
        repeat (4) @(posedge hclk);
        `CHK({hi, lo}, 2'b00)
        wait_state(3'h0);
        report_and_stop;
    end
endmodule : buck_boost_pwm_drive_control_bench
